// *** gpmx_pkg.sv ***
// constants and carrier types for the gpio port function multiplexer
package gpmx_pkg;

  // port widths, port c keeps eight logic bits but six pads
  localparam int GPMX_PA_W = 8;
  localparam int GPMX_PB_W = 8;
  localparam int GPMX_PC_W = 8;
  localparam int GPMX_PC_PINS = 6;
  localparam int GPMX_PD_W = 4;
  localparam int GPMX_PC_BIT [0:5] = '{0, 1, 2, 4, 5, 6};

  // function registers: 1 = peripheral, 0 = gpio
  localparam logic [7:0] GPMX_FN_A_RST = 8'h80;
  localparam logic [7:0] GPMX_FN_B_RST = 8'h00;
  localparam logic [7:0] GPMX_FN_C_RST = 8'hFF;
  localparam logic [3:0] GPMX_FN_D_RST = 4'hF;

  // index of each port in the function write strobe
  localparam int GPMX_FN_WR_A = 0;
  localparam int GPMX_FN_WR_B = 1;
  localparam int GPMX_FN_WR_C = 2;
  localparam int GPMX_FN_WR_D = 3;

  // peripheral select register layout
  localparam int GPMX_PS_W = 16;
  localparam logic [15:0] GPMX_PS_RST = 16'h0000;
  localparam int GPMX_PS_A4 = 0;
  localparam int GPMX_PS_A5 = 2;
  localparam int GPMX_PS_B0 = 4;

  // select codes, three-way pins
  localparam logic [1:0] GPMX_SEL_PWM = 2'h0;
  localparam logic [1:0] GPMX_SEL_FAULT = 2'h1;
  localparam logic [1:0] GPMX_SEL_TMR = 2'h2;
  // select codes, two-way pins
  localparam logic [1:0] GPMX_SEL_FIRST = 2'h0;
  localparam logic [1:0] GPMX_SEL_SECOND = 2'h1;
  localparam logic [1:0] GPMX_SEL_NONE = 2'h2;

  localparam int GPMX_ALT_N = 3;

  typedef struct packed {
    logic dout;
    logic oe;
  } gpmx_drv_s;

  localparam gpmx_drv_s GPMX_DRV_OFF = '{dout: 1'b0, oe: 1'b0};

  typedef struct packed {
    logic [7:0] gpio_a;
    logic [7:0] gpio_b;
    logic [7:0] gpio_c;
    logic [3:0] gpio_d;
    logic [3:0] fault;
    logic [3:0] tmr;
    logic [3:0] spi;
    logic i2c_scl;
    logic i2c_sda;
    logic sci_rxd;
    logic ext_clk;
    logic ext_rst_n;
    logic [2:0] jtag;
  } gpmx_pin_in_s;

  localparam gpmx_pin_in_s GPMX_PIN_IN_RST = '{gpio_a: 8'h00, gpio_b: 8'h00,
    gpio_c: 8'h00, gpio_d: 4'h0, fault: 4'h0, tmr: 4'h0, spi: 4'h0,
    i2c_scl: 1'b1, i2c_sda: 1'b1, sci_rxd: 1'b1, ext_clk: 1'b0,
    ext_rst_n: 1'b1, jtag: 3'h0};

endpackage : gpmx_pkg

// *** gpmx_reg.sv ***
// loadable register with constant reset value
module gpmx_reg #(
  parameter int W = 8,
  parameter logic [W-1:0] RST = '0
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // load
  input wire logic i_ld,
  input wire logic [W-1:0] i_d,
  // value
  output logic [W-1:0] o_q
);

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_q <= RST;
    end else if (i_ld) begin
      o_q <= i_d;
    end
  end

endmodule : gpmx_reg

// *** gpmx_pin_cell.sv ***
// one pad: gpio or one of n alternate drivers, registered
module gpmx_pin_cell #(
  parameter int N = 3,
  parameter int SW = 2
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // candidates
  input wire gpmx_pkg::gpmx_drv_s i_gpio,
  input wire gpmx_pkg::gpmx_drv_s [N-1:0] i_alt,
  input wire logic [SW-1:0] i_sel,
  input wire logic i_alt_mode,
  // pad drive
  output gpmx_pkg::gpmx_drv_s o_pad
);
  import gpmx_pkg::*;

  // out of range codes fall back to released pad
  wire gpmx_drv_s alt_pick = (32'(i_sel) < N) ? i_alt[i_sel] : GPMX_DRV_OFF;
  // gpio mode ignores peripheral drive entirely
  wire gpmx_drv_s nxt = i_alt_mode ? alt_pick : i_gpio;

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pad <= GPMX_DRV_OFF;
    end else begin
      o_pad <= nxt;
    end
  end

endmodule : gpmx_pin_cell

// *** gpmx_top.sv ***
// chip-level pin function multiplexer for gpio ports a to d
module gpmx_top (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // pads
  input wire logic [7:0] i_pad_a,
  input wire logic [7:0] i_pad_b,
  input wire logic [5:0] i_pad_c,
  input wire logic [3:0] i_pad_d,
  output gpmx_pkg::gpmx_drv_s [7:0] o_pad_a,
  output gpmx_pkg::gpmx_drv_s [7:0] o_pad_b,
  output gpmx_pkg::gpmx_drv_s [5:0] o_pad_c,
  output gpmx_pkg::gpmx_drv_s [3:0] o_pad_d,
  // gpio port logic
  input wire gpmx_pkg::gpmx_drv_s [7:0] i_gpio_a,
  input wire gpmx_pkg::gpmx_drv_s [7:0] i_gpio_b,
  input wire gpmx_pkg::gpmx_drv_s [7:0] i_gpio_c,
  input wire gpmx_pkg::gpmx_drv_s [3:0] i_gpio_d,
  input wire logic [3:0] i_fn_wr,
  input wire logic [7:0] i_fn_wdata,
  output logic [7:0] o_fn_a,
  output logic [7:0] o_fn_b,
  output logic [7:0] o_fn_c,
  output logic [3:0] o_fn_d,
  // system integration select register
  input wire logic i_psel_wr,
  input wire logic [15:0] i_psel_wdata,
  output logic [15:0] o_psel,
  // clock generator module
  input wire logic i_pll_ext_clk_en,
  // peripheral drivers
  input wire gpmx_pkg::gpmx_drv_s [5:0] i_pwm_drv,
  input wire gpmx_pkg::gpmx_drv_s [3:0] i_tmr_drv,
  input wire gpmx_pkg::gpmx_drv_s [3:0] i_spi_drv,
  input wire gpmx_pkg::gpmx_drv_s i_i2c_scl_drv,
  input wire gpmx_pkg::gpmx_drv_s i_i2c_sda_drv,
  input wire gpmx_pkg::gpmx_drv_s i_sci_txd_drv,
  input wire gpmx_pkg::gpmx_drv_s i_clko_drv,
  input wire gpmx_pkg::gpmx_drv_s i_tdo_drv,
  // pad values to gpio and peripherals
  output gpmx_pkg::gpmx_pin_in_s o_pin_in
);
  import gpmx_pkg::*;

  logic [7:0] fn_a;
  logic [7:0] fn_b;
  logic [7:0] fn_c;
  logic [3:0] fn_d;
  logic [15:0] psel_r;

  // function registers, loaded by the gpio port logic
  gpmx_reg #(.W(8), .RST(GPMX_FN_A_RST)) u_fn_a (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_ld(i_fn_wr[GPMX_FN_WR_A]),
    .i_d(i_fn_wdata),
    .o_q(fn_a)
  );
  gpmx_reg #(.W(8), .RST(GPMX_FN_B_RST)) u_fn_b (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_ld(i_fn_wr[GPMX_FN_WR_B]),
    .i_d(i_fn_wdata),
    .o_q(fn_b)
  );
  gpmx_reg #(.W(8), .RST(GPMX_FN_C_RST)) u_fn_c (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_ld(i_fn_wr[GPMX_FN_WR_C]),
    .i_d(i_fn_wdata),
    .o_q(fn_c)
  );
  gpmx_reg #(.W(4), .RST(GPMX_FN_D_RST)) u_fn_d (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_ld(i_fn_wr[GPMX_FN_WR_D]),
    .i_d(i_fn_wdata[3:0]),
    .o_q(fn_d)
  );

  // default selects are all zero, so each shared pin starts on its first alternate function
  gpmx_reg #(.W(GPMX_PS_W), .RST(GPMX_PS_RST)) u_psel (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_ld(i_psel_wr),
    .i_d(i_psel_wdata),
    .o_q(psel_r)
  );

  assign o_fn_a = fn_a;
  assign o_fn_b = fn_b;
  assign o_fn_c = fn_c;
  assign o_fn_d = fn_d;
  assign o_psel = psel_r;

  // select fields
  wire logic [1:0] sel_a4 = psel_r[GPMX_PS_A4 +: 2];
  wire logic [1:0] sel_a5 = psel_r[GPMX_PS_A5 +: 2];
  wire logic [7:0] sel_b = psel_r[GPMX_PS_B0 +: 8];

  // alternate driver tables, entry index is the select code
  gpmx_drv_s [2:0] alt_a [8];
  gpmx_drv_s [2:0] alt_b [8];
  logic [1:0] sel_a [8];
  logic [1:0] sel_bx [8];
  logic [7:0] mode_b;

  assign alt_a[0] = {GPMX_DRV_OFF, GPMX_DRV_OFF, i_pwm_drv[0]};
  assign alt_a[1] = {GPMX_DRV_OFF, GPMX_DRV_OFF, i_pwm_drv[1]};
  assign alt_a[2] = {GPMX_DRV_OFF, GPMX_DRV_OFF, i_pwm_drv[2]};
  assign alt_a[3] = {GPMX_DRV_OFF, GPMX_DRV_OFF, i_pwm_drv[3]};
  assign alt_a[4] = {i_tmr_drv[2], GPMX_DRV_OFF, i_pwm_drv[4]};
  assign alt_a[5] = {i_tmr_drv[3], GPMX_DRV_OFF, i_pwm_drv[5]};
  // fault and reset pins are inputs only
  assign alt_a[6] = {GPMX_DRV_OFF, GPMX_DRV_OFF, GPMX_DRV_OFF};
  assign alt_a[7] = {GPMX_DRV_OFF, GPMX_DRV_OFF, GPMX_DRV_OFF};

  assign alt_b[0] = {GPMX_DRV_OFF, i_i2c_scl_drv, i_spi_drv[0]};
  assign alt_b[1] = {GPMX_DRV_OFF, i_i2c_sda_drv, i_spi_drv[1]};
  assign alt_b[2] = {GPMX_DRV_OFF, i_tmr_drv[2], i_spi_drv[2]};
  assign alt_b[3] = {GPMX_DRV_OFF, i_tmr_drv[3], i_spi_drv[3]};
  assign alt_b[4] = {GPMX_DRV_OFF, i_clko_drv, i_tmr_drv[0]};
  assign alt_b[5] = {GPMX_DRV_OFF, GPMX_DRV_OFF, i_tmr_drv[1]};
  assign alt_b[6] = {GPMX_DRV_OFF, i_i2c_sda_drv, GPMX_DRV_OFF};
  assign alt_b[7] = {GPMX_DRV_OFF, i_i2c_scl_drv, i_sci_txd_drv};

  assign sel_a[0] = GPMX_SEL_FIRST;
  assign sel_a[1] = GPMX_SEL_FIRST;
  assign sel_a[2] = GPMX_SEL_FIRST;
  assign sel_a[3] = GPMX_SEL_FIRST;
  assign sel_a[4] = sel_a4;
  assign sel_a[5] = sel_a5;
  assign sel_a[6] = GPMX_SEL_FIRST;
  assign sel_a[7] = GPMX_SEL_FIRST;

  // external clock takes b6 over and releases it, whatever the select says
  wire logic ext_clk_on = i_pll_ext_clk_en;

  genvar gi;
  generate
    for (gi = 0; gi < GPMX_PB_W; gi++) begin : g_bsel
      if (gi == 6) begin : g_b6
        assign sel_bx[gi] = ext_clk_on ? GPMX_SEL_NONE : {1'b0, sel_b[gi]};
        assign mode_b[gi] = fn_b[gi] | ext_clk_on;
      end else begin : g_bn
        assign sel_bx[gi] = {1'b0, sel_b[gi]};
        assign mode_b[gi] = fn_b[gi];
      end
    end

    for (gi = 0; gi < GPMX_PA_W; gi++) begin : g_pa
      gpmx_pin_cell #(.N(GPMX_ALT_N), .SW(2)) u_cell (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_gpio(i_gpio_a[gi]),
        .i_alt(alt_a[gi]),
        .i_sel(sel_a[gi]),
        .i_alt_mode(fn_a[gi]),
        .o_pad(o_pad_a[gi])
      );
    end

    for (gi = 0; gi < GPMX_PB_W; gi++) begin : g_pb
      gpmx_pin_cell #(.N(GPMX_ALT_N), .SW(2)) u_cell (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_gpio(i_gpio_b[gi]),
        .i_alt(alt_b[gi]),
        .i_sel(sel_bx[gi]),
        .i_alt_mode(mode_b[gi]),
        .o_pad(o_pad_b[gi])
      );
    end

    // only bonded bits get a pad cell; bits three and seven stay logic only
    for (gi = 0; gi < GPMX_PC_PINS; gi++) begin : g_pc
      gpmx_pin_cell #(.N(1), .SW(1)) u_cell (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_gpio(i_gpio_c[GPMX_PC_BIT[gi]]),
        .i_alt(GPMX_DRV_OFF),
        .i_sel(1'b0),
        .i_alt_mode(fn_c[GPMX_PC_BIT[gi]]),
        .o_pad(o_pad_c[gi])
      );
    end

    for (gi = 0; gi < GPMX_PD_W; gi++) begin : g_pd
      gpmx_pin_cell #(.N(1), .SW(1)) u_cell (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_gpio(i_gpio_d[gi]),
        .i_alt((gi == 1) ? i_tdo_drv : GPMX_DRV_OFF),
        .i_sel(1'b0),
        .i_alt_mode(fn_d[gi]),
        .o_pad(o_pad_d[gi])
      );
    end
  endgenerate

  // port c read-back, unbonded bits read zero
  logic [7:0] pc_in;
  assign pc_in = {1'b0, i_pad_c[5:3], 1'b0, i_pad_c[2:0]};

  // input routing follows the select and the external clock enable, not the gpio mode; only the a7 reset follows fn_a[7]
  wire logic a4_fault = (sel_a4 == GPMX_SEL_FAULT);
  wire logic a4_tmr = (sel_a4 == GPMX_SEL_TMR);
  wire logic a5_fault = (sel_a5 == GPMX_SEL_FAULT);
  wire logic a5_tmr = (sel_a5 == GPMX_SEL_TMR);

  gpmx_pin_in_s pin_in_nxt;

  assign pin_in_nxt.gpio_a = i_pad_a;
  assign pin_in_nxt.gpio_b = i_pad_b;
  assign pin_in_nxt.gpio_c = pc_in;
  assign pin_in_nxt.gpio_d = i_pad_d;
  assign pin_in_nxt.fault[0] = i_pad_a[6];
  assign pin_in_nxt.fault[1] = a4_fault & i_pad_a[4];
  assign pin_in_nxt.fault[2] = a5_fault & i_pad_a[5];
  assign pin_in_nxt.fault[3] = sel_b[5] & i_pad_b[5];
  assign pin_in_nxt.tmr[0] = ~sel_b[4] & i_pad_b[4];
  assign pin_in_nxt.tmr[1] = ~sel_b[5] & i_pad_b[5];
  // a timer channel mapped on two pins prefers port a
  assign pin_in_nxt.tmr[2] = a4_tmr ? i_pad_a[4] : (sel_b[2] & i_pad_b[2]);
  assign pin_in_nxt.tmr[3] = a5_tmr ? i_pad_a[5] : (sel_b[3] & i_pad_b[3]);
  assign pin_in_nxt.spi = ~sel_b[3:0] & i_pad_b[3:0];
  // idle level of the bus lines is high
  assign pin_in_nxt.i2c_scl = sel_b[0] ? i_pad_b[0] : (sel_b[7] ? i_pad_b[7] : 1'b1);
  assign pin_in_nxt.i2c_sda = sel_b[1] ? i_pad_b[1] : (sel_b[6] ? i_pad_b[6] : 1'b1);
  assign pin_in_nxt.sci_rxd = (!ext_clk_on && !sel_b[6]) ? i_pad_b[6] : 1'b1;
  assign pin_in_nxt.ext_clk = ext_clk_on & i_pad_b[6];
  // a7 asserts reset only while it holds the reset function
  assign pin_in_nxt.ext_rst_n = fn_a[7] ? i_pad_a[7] : 1'b1;
  assign pin_in_nxt.jtag = {i_pad_d[3], i_pad_d[2], i_pad_d[0]};

  gpmx_reg #(.W($bits(gpmx_pin_in_s)), .RST(GPMX_PIN_IN_RST)) u_pin_in (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_ld(1'b1),
    .i_d(pin_in_nxt),
    .o_q(o_pin_in)
  );

endmodule : gpmx_top

// *** gpmx_assertions.sv ***
// concurrent checks on the pin function multiplexer ports
module gpmx_assertions (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // control
  input wire logic [7:0] o_fn_a,
  input wire logic [7:0] o_fn_b,
  input wire logic i_psel_wr,
  input wire logic [15:0] i_psel_wdata,
  input wire logic [15:0] o_psel,
  input wire logic i_pll_ext_clk_en,
  // drive and pads
  input wire gpmx_pkg::gpmx_drv_s [5:0] i_pwm_drv,
  input wire gpmx_pkg::gpmx_drv_s [3:0] i_tmr_drv,
  input wire gpmx_pkg::gpmx_drv_s [3:0] i_spi_drv,
  input wire gpmx_pkg::gpmx_drv_s i_i2c_scl_drv,
  input wire gpmx_pkg::gpmx_drv_s [7:0] i_gpio_b,
  input wire logic [7:0] i_pad_a,
  input wire logic [7:0] i_pad_b,
  input wire gpmx_pkg::gpmx_drv_s [7:0] o_pad_a,
  input wire gpmx_pkg::gpmx_drv_s [7:0] o_pad_b,
  input wire gpmx_pkg::gpmx_pin_in_s o_pin_in
);
  import gpmx_pkg::*;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  a_psel_write: assert property (i_psel_wr |=> o_psel == $past(i_psel_wdata))
    else $error("select write lost");
  a_a4_pwm: assert property ((o_fn_a[4] && o_psel[1:0] == GPMX_SEL_PWM)
    |=> o_pad_a[4] == $past(i_pwm_drv[4])) else $error("a4 pwm");
  a_a4_tmr: assert property ((o_fn_a[4] && o_psel[1:0] == GPMX_SEL_TMR)
    |=> o_pad_a[4] == $past(i_tmr_drv[2])) else $error("a4 timer");
  a_a5_fault: assert property ((o_fn_a[5] && o_psel[3:2] == GPMX_SEL_FAULT)
    |=> !o_pad_a[5].oe) else $error("a5 fault driven");
  a_b0_select: assert property (o_fn_b[0] |=> o_pad_b[0] ==
    $past(o_psel[4] ? i_i2c_scl_drv : i_spi_drv[0])) else $error("b0 select");
  a_gpio_own: assert property (!o_fn_b[0] |=> o_pad_b[0] == $past(i_gpio_b[0]))
    else $error("b0 gpio");
  a_ext_clk_off: assert property (i_pll_ext_clk_en |=> !o_pad_b[6].oe)
    else $error("b6 driven");
  a_rst_input: assert property (o_fn_a[7] |=> o_pin_in.ext_rst_n == $past(i_pad_a[7]))
    else $error("reset input");
  a_fault_input_3_route: assert property (o_psel[9] |=> o_pin_in.fault[3] == $past(i_pad_b[5]))
    else $error("fault_input_3 route");
  a_rxd_route: assert property ((!i_pll_ext_clk_en && !o_psel[10])
    |=> o_pin_in.sci_rxd == $past(i_pad_b[6])) else $error("rxd route");
  a_sda_route: assert property (o_psel[5] |=> o_pin_in.i2c_sda == $past(i_pad_b[1]))
    else $error("sda route");
  a_pc_gap: assert property (o_pin_in.gpio_c[3] == 1'b0 && o_pin_in.gpio_c[7] == 1'b0)
    else $error("c gap bit set");
  c_a4_timer: cover property (o_fn_a[4] && o_psel[1:0] == GPMX_SEL_TMR);
  c_b6_sda: cover property (o_fn_b[6] && o_psel[10]);
  c_ext_clk: cover property (i_pll_ext_clk_en && o_fn_b[6]);
endmodule : gpmx_assertions

bind gpmx_top gpmx_assertions u_gpmx_assertions (
  .i_core_clk(i_core_clk), .i_rst(i_rst), .o_fn_a(o_fn_a), .o_fn_b(o_fn_b),
  .i_psel_wr(i_psel_wr), .i_psel_wdata(i_psel_wdata), .o_psel(o_psel),
  .i_pll_ext_clk_en(i_pll_ext_clk_en), .i_pwm_drv(i_pwm_drv), .i_tmr_drv(i_tmr_drv),
  .i_spi_drv(i_spi_drv), .i_i2c_scl_drv(i_i2c_scl_drv), .i_gpio_b(i_gpio_b),
  .i_pad_a(i_pad_a), .i_pad_b(i_pad_b), .o_pad_a(o_pad_a), .o_pad_b(o_pad_b),
  .o_pin_in(o_pin_in)
);

// *** gpmx_periph_model.sv ***
// peripherals that drive the shared pins from a bench pattern
module gpmx_periph_model (
  // pattern
  input wire logic [7:0] i_pat,
  // peripheral drive, always enabled
  output gpmx_pkg::gpmx_drv_s [5:0] o_pwm,
  output gpmx_pkg::gpmx_drv_s [3:0] o_tmr,
  output gpmx_pkg::gpmx_drv_s [3:0] o_spi,
  output gpmx_pkg::gpmx_drv_s o_scl,
  output gpmx_pkg::gpmx_drv_s o_sda,
  output gpmx_pkg::gpmx_drv_s o_clko,
  output gpmx_pkg::gpmx_drv_s o_tdo
);
  import gpmx_pkg::*;
  for (genvar k = 0; k < 6; k++) begin : g_pwm
    assign o_pwm[k] = '{dout: i_pat[k], oe: 1'b1};
  end
  // timer inverted so it differs from pwm on shared pins
  for (genvar k = 0; k < 4; k++) begin : g_tmr
    assign o_tmr[k] = '{dout: ~i_pat[k], oe: 1'b1};
    assign o_spi[k] = '{dout: i_pat[k+4], oe: 1'b1};
  end
  assign o_scl = '{dout: i_pat[6], oe: 1'b1};
  assign o_sda = '{dout: ~i_pat[7], oe: 1'b1};
  assign o_clko = '{dout: i_pat[1], oe: 1'b1};
  assign o_tdo = '{dout: i_pat[2], oe: 1'b1};
endmodule : gpmx_periph_model

// *** gpmx_top_tb.sv ***
// self-checking bench for the pin function multiplexer
module gpmx_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import gpmx_pkg::*;
  logic i_core_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [7:0] pad_a = 8'h00, pad_b = 8'h00, pat = 8'h00, fn_wd = 8'h00;
  logic [3:0] pad_d = 4'h9, fn_wr = 4'h0;
  logic [5:0] pad_c = 6'h3F;
  logic ps_wr = 1'b0, ext_clk_en = 1'b0;
  logic [15:0] ps_wd = 16'h0000;
  gpmx_drv_s [7:0] gp_b = 16'h5555;
  // neighbouring bits differ so a wrong port c cell mapping shows
  gpmx_drv_s [7:0] gp_c = 16'hDB1B;
  gpmx_drv_s [7:0] pd_a, pd_b;
  gpmx_drv_s [5:0] pd_c;
  gpmx_drv_s [3:0] pd_d, tmr, spi;
  gpmx_drv_s [5:0] pwm;
  gpmx_drv_s scl, sda, clko, tdo;
  logic [7:0] fa, fb, fc;
  logic [3:0] fd;
  logic [15:0] ps;
  gpmx_pin_in_s pin;
  int mismatches = 0, samples_checked = 0, cycles = 0;
  localparam logic [1:0] e4 [4] = '{2'h3, 2'h0, 2'h1, 2'h0};
  localparam logic [1:0] e5 [4] = '{2'h3, 2'h0, 2'h3, 2'h0};

  gpmx_top u_gpmx_top (.i_core_clk(i_core_clk), .i_rst(i_rst),
    .i_pad_a(pad_a), .i_pad_b(pad_b), .i_pad_c(pad_c), .i_pad_d(pad_d),
    .o_pad_a(pd_a), .o_pad_b(pd_b), .o_pad_c(pd_c), .o_pad_d(pd_d),
    .i_gpio_a(16'h5555), .i_gpio_b(gp_b), .i_gpio_c(gp_c), .i_gpio_d(8'h00),
    .i_fn_wr(fn_wr), .i_fn_wdata(fn_wd), .o_fn_a(fa), .o_fn_b(fb), .o_fn_c(fc),
    .o_fn_d(fd), .i_psel_wr(ps_wr), .i_psel_wdata(ps_wd), .o_psel(ps),
    .i_pll_ext_clk_en(ext_clk_en), .i_pwm_drv(pwm), .i_tmr_drv(tmr), .i_spi_drv(spi),
    .i_i2c_scl_drv(scl), .i_i2c_sda_drv(sda), .i_sci_txd_drv(2'h0),
    .i_clko_drv(clko), .i_tdo_drv(tdo), .o_pin_in(pin));
  gpmx_periph_model u_gpmx_periph_model (.i_pat(pat), .o_pwm(pwm), .o_tmr(tmr),
    .o_spi(spi), .o_scl(scl), .o_sda(sda), .o_clko(clko), .o_tdo(tdo));

  initial begin
    forever #2.5 i_core_clk = ~i_core_clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // back-to-back writes, then room for the pad stage
  task automatic wr(input logic [7:0] a, input logic [7:0] b, input logic [15:0] s);
    @(negedge i_core_clk);
    fn_wr = 4'h1;
    fn_wd = a;
    @(negedge i_core_clk);
    fn_wr = 4'h2;
    fn_wd = b;
    ps_wr = 1'b1;
    ps_wd = s;
    @(negedge i_core_clk);
    fn_wr = 4'h0;
    ps_wr = 1'b0;
    repeat (2) @(negedge i_core_clk);
  endtask : wr

  task automatic t_reset();
    chk(fa, 16'h0080);
    chk(fb, 16'h0000);
    chk(fc, 16'h00FF);
    chk(fd, 16'h000F);
    chk(ps, 16'h0000);
    chk(pd_c, 16'h0000);
    chk(pd_a[0], 16'h0001);
    chk(pd_d[1], 16'h0001);
    chk(pin.ext_rst_n, 16'h0000);
    chk(pin.jtag, 16'h0005);
    chk(pin.gpio_c, 16'h0077);
    $display("test reset done");
  endtask : t_reset

  task automatic t_a45();
    pad_a = 8'h30;
    pat = 8'h35;
    for (int c = 0; c < 4; c++) begin
      wr(8'hB0, 8'h00, {12'h000, c[1:0], c[1:0]});
      chk(pd_a[4], e4[c]);
      chk(pd_a[5], e5[c]);
      chk(pin.fault[1], c == 1);
      chk(pin.fault[2], c == 1);
      chk(pin.tmr[2], c == 2);
    end
    $display("test a4 a5 done");
  endtask : t_a45

  task automatic t_port_b();
    pad_b = 8'h22;
    pat = 8'h43;
    for (int s = 0; s < 2; s++) begin
      wr(8'h80, 8'hFF, s ? 16'h0FF0 : 16'h0000);
      chk(pd_b[0], s ? 3 : 1);
      chk(pd_b[1], s ? 3 : 1);
      chk(pd_b[5], s ? 0 : 1);
      chk(pd_b[6], s ? 3 : 0);
      chk(pd_b[7], s ? 3 : 0);
      chk(pin.i2c_scl, s ? 0 : 1);
      chk(pin.fault[3], s);
      chk(pin.tmr[1], !s);
      chk(pin.sci_rxd, s ? 1 : 0);
    end
    $display("test port b done");
  endtask : t_port_b

  task automatic t_ext_clk();
    pad_b = 8'h00;
    ext_clk_en = 1'b1;
    wr(8'h80, 8'hFF, 16'h0000);
    chk(pd_b[6].oe, 16'h0000);
    chk(pin.sci_rxd, 16'h0001);
    pad_b = 8'h40;
    repeat (2) @(negedge i_core_clk);
    chk(pin.ext_clk, 16'h0001);
    ext_clk_en = 1'b0;
    $display("test ext clock done");
  endtask : t_ext_clk

  // gpio mode ignores peripheral drive but pad still feeds spi
  task automatic t_gpio();
    gp_b = 16'hAAAA;
    pad_b = 8'h01;
    pad_c = 6'h29;
    wr(8'h80, 8'h00, 16'h0000);
    chk(pd_b[0], 16'h0002);
    chk(pin.spi[0], 16'h0001);
    chk(pin.gpio_b, 16'h0001);
    chk(pin.gpio_c, 16'h0051);
    // port c to gpio so each of its six cells shows its own gpio bit
    @(negedge i_core_clk);
    fn_wr = 4'h4;
    fn_wd = 8'h00;
    @(negedge i_core_clk);
    fn_wr = 4'h0;
    repeat (2) @(negedge i_core_clk);
    chk(pd_c, 16'h06DB);
    $display("test gpio done");
  endtask : t_gpio

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  always @(posedge i_core_clk) begin
    cycles++;
    if (cycles == 1000) begin
      mismatches++;
      complete_run();
    end
  end

  initial begin
    repeat (3) @(negedge i_core_clk);
    i_rst = 1'b0;
    @(negedge i_core_clk);
    t_reset();
    t_a45();
    t_port_b();
    t_ext_clk();
    t_gpio();
    complete_run();
  end
endmodule : gpmx_top_tb
